// ---- common/srh_pkg.sv ----
// status reporting hierarchy: shared constants and carriers
// assumes a single 25 MHz system clock and synchronous reset
package srh_pkg;
   // ----------------------------------------
   // status byte bit positions
   // ----------------------------------------
   localparam int STB_QUEUE_BIT = 2;
   localparam int STB_QUES_BIT = 3;
   localparam int STB_MAV_BIT = 4;
   localparam int STB_ESB_BIT = 5;
   localparam int STB_RQS_BIT = 6;
   localparam int STB_OPER_BIT = 7;
   // ----------------------------------------
   // standard event bit positions
   // ----------------------------------------
   localparam int ESR_OPC_BIT = 0;
   localparam int ESR_QUERY_BIT = 2;
   localparam int ESR_DDE_BIT = 3;
   localparam int ESR_EXE_BIT = 4;
   localparam int ESR_CMD_BIT = 5;
   localparam int ESR_PON_BIT = 7;
   // ----------------------------------------
   // operation condition bit positions
   // ----------------------------------------
   localparam int OPER_SETTLING_BIT = 1;
   localparam int OPER_UNUSED_BIT = 2;
   localparam int OPER_SWEEP_BIT = 3;
   localparam int OPER_TRIG_BIT = 5;
   localparam int ALWAYS_ZERO_BIT = 15;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [15:0] PTR_RESET = 16'h7FFF;
   localparam logic [15:0] NTR_RESET = 16'h0000;
   localparam logic [15:0] ENA_RESET = 16'h0000;
   localparam logic [7:0] ESR_RESET = 8'h00;
   localparam logic [7:0] SRE_RESET = 8'h00;
   // group selector for status subsystem writes and reads
   typedef enum logic [1:0] {
      SRH_GRP_OPER = 2'b00,
      SRH_GRP_QUES = 2'b01,
      SRH_GRP_FREQ = 2'b11
   } srh_grp_e;
   // register selector within a group
   typedef enum logic [1:0] {
      SRH_REG_PTR = 2'b00,
      SRH_REG_NTR = 2'b01,
      SRH_REG_ENA = 2'b11,
      SRH_REG_EVT = 2'b10
   } srh_reg_e;
   // one status subsystem access
   typedef struct packed {
      logic wr;
      logic rd;
      srh_grp_e grp;
      srh_reg_e sel;
      logic [15:0] data;
   } srh_stat_req_s;
   // one common (asterisk) command access
   typedef struct packed {
      logic cls;
      logic ese_wr;
      logic sre_wr;
      logic esr_rd;
      logic [7:0] data;
   } srh_common_req_s;
endpackage : srh_pkg

// ---- verilog/srh_status.sv ----
// status reporting hierarchy: condition, filter, event, enable groups and status byte
// assumes the command decoder presents decoded commands as one-cycle pulses on clk
//
// What this block does
// [RL1] each lower group sends one summary bit to the next register up
// [RL2] status byte sits on top and collects all lower summaries
// [RL3] frequency group has condition, two filters, event and enable registers
// [RL4] operation condition carries a settling bit from the generator
// [RL5] status byte bit 2 shows error and event queue not empty
// [RL6] status byte bit 4 shows an output message is available
// [RL7] status byte bit 5 is the standard event summary
// [RL8] status byte bit 6 is request service summary
// [RL9] status byte bit 7 is the standard operation summary
// [RL10] standard event bit 2 query error, bit 3 device error
// [RL11] standard event bit 4 execution error, bit 5 command error
// [RL12] operation bit 1 settling, bit 2 unused, bit 3 sweep_in_progress
// [RL13] operation bit 5 set while awaiting a trigger
// [RL14] asterisk commands reach summaries, status commands reach lower groups
// [RL15] bit 15 of every 16-bit register reads zero
// [RL16] event bits latch on filtered transition until read or clear status
// [RL17] filters reset to positive transitions only, reconfigurable
// [RL18] service request only from enabled bits, any one of them sets rqs
// [RL19] group summary is OR of event AND enable
// [RL20] reset clears events then sets power-on bit
`timescale 1ns/1ps
module srh_status #(
   parameter int FREQ_W = 15
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // asynchronous instrument conditions
   input wire logic settling,
   input wire logic sweep_in_progress,
   input wire logic awaiting_trigger,
   input wire logic [15:0] freq_cond_in,
   input wire logic queue_not_empty,
   input wire logic output_message_available,
   // standard event pulses from the command engine
   input wire logic [7:0] esr_set,
   // decoded commands
   input wire srh_pkg::srh_stat_req_s stat_req,
   input wire srh_pkg::srh_common_req_s common_req,
   // results
   output logic [15:0] stat_rdata,
   output logic [7:0] esr_rdata,
   output logic [7:0] status_byte,
   output logic [7:0] sre_q,
   output logic [7:0] ese_q,
   output logic service_request
);
   // bit 15 must always read zero, so the frequency group holds at most 15 live bits
   if (FREQ_W < 1 || FREQ_W > 15) begin : gen_bad_freq_w
      $error("FREQ_W out of range");
   end

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   logic [18:0] sync1_r, sync2_r;
   logic [18:0] raw;
   assign raw = {settling, sweep_in_progress, awaiting_trigger, freq_cond_in};
   // pins are asynchronous to clk, so two flops before any use
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= raw;
         sync2_r <= sync1_r;
      end
   end
   logic [1:0] q_sync1_r, q_sync2_r;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q_sync1_r <= '0;
         q_sync2_r <= '0;
      end else begin
         q_sync1_r <= {queue_not_empty, output_message_available};
         q_sync2_r <= q_sync1_r;
      end
   end

   // ----------------------------------------
   // condition registers
   // ----------------------------------------
   logic [15:0] cond [3];
   logic [15:0] oper_cond, freq_cond;
   always_comb begin
      oper_cond = 16'h0000;
      oper_cond[srh_pkg::OPER_SETTLING_BIT] = sync2_r[18]; // RL4 RL12
      oper_cond[srh_pkg::OPER_UNUSED_BIT] = 1'b0; // RL12
      oper_cond[srh_pkg::OPER_SWEEP_BIT] = sync2_r[17]; // RL12
      oper_cond[srh_pkg::OPER_TRIG_BIT] = sync2_r[16]; // RL13
      freq_cond = 16'h0000;
      freq_cond[FREQ_W-1:0] = sync2_r[FREQ_W-1:0]; // RL15
   end
   logic ques_sum;
   assign cond[0] = oper_cond;
   assign cond[1] = {15'h0000, ques_sum} & 16'h7FFF;
   assign cond[2] = freq_cond;

   // ----------------------------------------
   // transition filter, event and enable groups
   // ----------------------------------------
   // index 0 operation, 1 questionable, 2 frequency questionable
   function automatic int grp_idx(input srh_pkg::srh_grp_e g);
      case (g)
         srh_pkg::SRH_GRP_OPER: grp_idx = 0;
         srh_pkg::SRH_GRP_QUES: grp_idx = 1;
         srh_pkg::SRH_GRP_FREQ: grp_idx = 2;
         default: grp_idx = 0;
      endcase
   endfunction : grp_idx

   logic [15:0] ptr_r [3];
   logic [15:0] ntr_r [3];
   logic [15:0] ena_r [3];
   logic [15:0] evt_r [3];
   logic [15:0] prev_r [3];
   logic [2:0] grp_sum;

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : gen_grp
         logic hit_wr, hit_rd;
         logic [15:0] trans;
         assign hit_wr = stat_req.wr && grp_idx(stat_req.grp) == g;
         assign hit_rd = stat_req.rd && grp_idx(stat_req.grp) == g && stat_req.sel == srh_pkg::SRH_REG_EVT;
         // filtered transitions of the condition register
         assign trans = ((cond[g] & ~prev_r[g] & ptr_r[g]) | (~cond[g] & prev_r[g] & ntr_r[g])) & 16'h7FFF;

         // filter and enable configuration
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               ptr_r[g] <= srh_pkg::PTR_RESET; // RL17
               ntr_r[g] <= srh_pkg::NTR_RESET; // RL17
               ena_r[g] <= srh_pkg::ENA_RESET;
            end else if (hit_wr) begin
               case (stat_req.sel)
                  srh_pkg::SRH_REG_PTR: ptr_r[g] <= stat_req.data & 16'h7FFF; // RL14 RL15
                  srh_pkg::SRH_REG_NTR: ntr_r[g] <= stat_req.data & 16'h7FFF; // RL14 RL15
                  srh_pkg::SRH_REG_ENA: ena_r[g] <= stat_req.data & 16'h7FFF; // RL15
                  default: ;
               endcase
            end
         end

         // condition history for edge detection
         always_ff @(posedge clk) begin
            if (sys_rst) prev_r[g] <= 16'h0000;
            else prev_r[g] <= cond[g];
         end

         // event latch: a new transition wins over a read clear
         always_ff @(posedge clk) begin
            if (sys_rst) evt_r[g] <= 16'h0000; // RL20
            else if (hit_rd || common_req.cls) evt_r[g] <= trans; // RL16
            else evt_r[g] <= evt_r[g] | trans; // RL16 RL3
         end

         assign grp_sum[g] = |(evt_r[g] & ena_r[g]); // RL19 RL1
      end
   endgenerate

   // frequency group feeds questionable group bit 0
   assign ques_sum = grp_sum[2]; // RL1

   // ----------------------------------------
   // status subsystem read mux
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) stat_rdata <= 16'h0000;
      else if (stat_req.rd) begin
         case (stat_req.sel)
            srh_pkg::SRH_REG_PTR: stat_rdata <= ptr_r[grp_idx(stat_req.grp)];
            srh_pkg::SRH_REG_NTR: stat_rdata <= ntr_r[grp_idx(stat_req.grp)];
            srh_pkg::SRH_REG_ENA: stat_rdata <= ena_r[grp_idx(stat_req.grp)];
            srh_pkg::SRH_REG_EVT: stat_rdata <= evt_r[grp_idx(stat_req.grp)]; // RL14
            default: stat_rdata <= 16'h0000;
         endcase
      end
   end

   // ----------------------------------------
   // standard event group
   // ----------------------------------------
   logic [7:0] esr_r, ese_r;
   logic pon_pending_r;
   // power-on bit is set on the first cycle after reset release
   always_ff @(posedge clk) begin
      if (sys_rst) pon_pending_r <= 1'b1;
      else pon_pending_r <= 1'b0;
   end
   logic [7:0] esr_in;
   always_comb begin
      esr_in = esr_set; // RL10 RL11: query, device, execution, command errors at bits 2..5
      esr_in[srh_pkg::ESR_PON_BIT] = esr_set[srh_pkg::ESR_PON_BIT] | pon_pending_r; // RL20
   end
   always_ff @(posedge clk) begin
      if (sys_rst) esr_r <= srh_pkg::ESR_RESET; // RL20
      else if (common_req.esr_rd || common_req.cls) esr_r <= esr_in; // RL16
      else esr_r <= esr_r | esr_in; // RL16
   end
   always_ff @(posedge clk) begin
      if (sys_rst) ese_r <= srh_pkg::ESR_RESET;
      else if (common_req.ese_wr) ese_r <= common_req.data; // RL14
   end
   always_ff @(posedge clk) begin
      if (sys_rst) esr_rdata <= 8'h00;
      else if (common_req.esr_rd) esr_rdata <= esr_r;
   end
   logic esb_sum;
   assign esb_sum = |(esr_r & ese_r); // RL19
   assign ese_q = ese_r;

   // ----------------------------------------
   // status byte and service request
   // ----------------------------------------
   logic [7:0] sre_r;
   logic [7:0] stb_raw;
   always_ff @(posedge clk) begin
      if (sys_rst) sre_r <= srh_pkg::SRE_RESET;
      else if (common_req.sre_wr) sre_r <= common_req.data & 8'hBF; // RL14
   end
   assign sre_q = sre_r;
   always_comb begin
      stb_raw = 8'h00;
      stb_raw[srh_pkg::STB_QUEUE_BIT] = q_sync2_r[1]; // RL5
      stb_raw[srh_pkg::STB_QUES_BIT] = grp_sum[1]; // RL1 RL2
      stb_raw[srh_pkg::STB_MAV_BIT] = q_sync2_r[0]; // RL6
      stb_raw[srh_pkg::STB_ESB_BIT] = esb_sum; // RL7
      stb_raw[srh_pkg::STB_OPER_BIT] = grp_sum[0]; // RL9 RL2
   end
   // rqs is one bit however many enabled sources assert it
   logic rqs_nxt;
   assign rqs_nxt = |(stb_raw & sre_r); // RL18
   always_ff @(posedge clk) begin
      if (sys_rst) status_byte <= 8'h00;
      else status_byte <= stb_raw | ({7'h00, rqs_nxt} << srh_pkg::STB_RQS_BIT); // RL8
   end
   assign service_request = status_byte[srh_pkg::STB_RQS_BIT]; // RL18

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   sequence s_rst_release;
      $fell(sys_rst);
   endsequence
   AST_PON_SET: assert property (@(posedge clk) s_rst_release |=> esr_r[srh_pkg::ESR_PON_BIT]) // RL20
      else $error("power-on bit not set after reset");
   AST_RQS_ENABLED: assert property (@(posedge clk) disable iff (sys_rst)
      status_byte[srh_pkg::STB_RQS_BIT] == $past(|(stb_raw & sre_r))) // RL18
      else $error("rqs does not follow enabled summary");
   AST_ESB_BIT: assert property (@(posedge clk) disable iff (sys_rst)
      status_byte[srh_pkg::STB_ESB_BIT] == $past(|(esr_r & ese_r))) // RL7
      else $error("event summary bit wrong");
   AST_OPER_BIT: assert property (@(posedge clk) disable iff (sys_rst)
      status_byte[srh_pkg::STB_OPER_BIT] == $past(|(evt_r[0] & ena_r[0]))) // RL9
      else $error("operation summary bit wrong");
   // two sync flops and the status byte flop: three or four edges after the pin moves
   AST_MAV_BIT: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(output_message_available) |-> ##[3:4] status_byte[srh_pkg::STB_MAV_BIT]) // RL6
      else $error("message available not reported");
   AST_QUEUE_BIT: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(queue_not_empty) |-> ##[3:4] status_byte[srh_pkg::STB_QUEUE_BIT]) // RL5
      else $error("queue bit not reported");
   AST_BIT15_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
      !evt_r[0][15] && !ptr_r[2][15] && !ena_r[1][15]) // RL15
      else $error("bit 15 not zero");
   // without a clear or a read, no latched frequency event may drop
   AST_EVT_STICKY: assert property (@(posedge clk) disable iff (sys_rst)
      (evt_r[2] != 16'h0000 && !common_req.cls && !(stat_req.rd && stat_req.grp == srh_pkg::SRH_GRP_FREQ))
      |=> (evt_r[2] & $past(evt_r[2])) == $past(evt_r[2])) // RL16
      else $error("event bit lost without clear");
   // clear status empties event registers, but a transition in that same cycle survives
   AST_CLS_CLEARS: assert property (@(posedge clk) disable iff (sys_rst)
      common_req.cls |=> esr_r == $past(esr_in) && (evt_r[0] & ~$past(cond[0] ^ prev_r[0])) == 16'h0000) // RL16
      else $error("clear status failed");
   AST_SETTLE_EVT: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(settling) && ptr_r[0][srh_pkg::OPER_SETTLING_BIT] && !common_req.cls && !stat_req.rd
      |-> ##3 evt_r[0][srh_pkg::OPER_SETTLING_BIT]) // RL4
      else $error("settling edge not latched");

   // a rising frequency summary must latch one level up on the next edge
   sequence s_freq_sum_rise;
      $rose(grp_sum[2]) && ptr_r[1][0];
   endsequence
   AST_QUES_FEED: assert property (@(posedge clk) disable iff (sys_rst)
      s_freq_sum_rise |=> evt_r[1][0]) // RL1
      else $error("frequency summary not forwarded");
   // a read of the standard event register hands it over and starts it afresh
   AST_ESR_READ_CLEARS: assert property (@(posedge clk) disable iff (sys_rst)
      common_req.esr_rd |=> esr_r == $past(esr_in) && esr_rdata == $past(esr_r)) // RL16
      else $error("event read did not clear");
   // enable bit 6 cannot be written, so rqs never enables itself
   AST_SRE_NO_RQS: assert property (@(posedge clk) disable iff (sys_rst)
      !sre_r[srh_pkg::STB_RQS_BIT]) // RL18
      else $error("service enable bit 6 set");
   // status byte bits 0 and 1 carry nothing, operation bit 2 never latches
   AST_UNUSED_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
      status_byte[1:0] == 2'b00 && !evt_r[0][srh_pkg::OPER_UNUSED_BIT]) // RL2 RL12
      else $error("unused bit set");
endmodule : srh_status

// ---- test/srh_ctrl_model.sv ----
// remote controller model: sends status subsystem and asterisk commands as one-cycle pulses
// assumes one bench process calls its tasks, each starting just after a clock edge
`timescale 1ns/1ps
module srh_ctrl_model (
   // clock
   input wire logic clk,
   // decoded commands toward the device
   output srh_pkg::srh_stat_req_s stat_req,
   output srh_pkg::srh_common_req_s common_req
);
   // idle at time zero, status data shows a junk pattern while nothing is sent, asterisk data starts at zero
   initial begin
      stat_req = '0;
      common_req = '0;
      stat_req.data = 16'hA5A5;
   end
   // status subsystem command; data flips once released so a stale value never looks valid
   task automatic stat_op(input logic w, input logic r, input srh_pkg::srh_grp_e g, input srh_pkg::srh_reg_e s,
                          input logic [15:0] d);
      @(posedge clk);
      stat_req <= '{w, r, g, s, d};
      @(posedge clk);
      stat_req.wr <= 1'b0;
      stat_req.rd <= 1'b0;
      stat_req.data <= ~d;
   endtask : stat_op
   // asterisk command, one pulse then released
   task automatic com_op(input logic [3:0] k, input logic [7:0] d);
      @(posedge clk);
      common_req <= '{k[3], k[2], k[1], k[0], d};
      @(posedge clk);
      common_req <= '{1'b0, 1'b0, 1'b0, 1'b0, ~d};
   endtask : com_op
endmodule : srh_ctrl_model

// ---- test/testbench.sv ----
// self-checking bench for the status reporting hierarchy
// assumes 25 MHz clock, sync reset held 20 cycles, commands from the controller model
`timescale 1ns/1ps
module testbench;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic settling = 1'b0;
   logic sweep_in_progress = 1'b0;
   logic awaiting_trigger = 1'b0;
   logic [15:0] freq_cond_in = 16'h0000;
   logic queue_not_empty = 1'b0;
   logic output_message_available = 1'b0;
   logic [7:0] esr_set = 8'h00;
   srh_pkg::srh_stat_req_s stat_req;
   srh_pkg::srh_common_req_s common_req;
   logic [15:0] stat_rdata;
   logic [7:0] esr_rdata, status_byte, sre_q, ese_q;
   logic service_request;
   int n_fail = 0;
   int checked = 0;
   int cycles = 0;
   always #20 clk = ~clk;
   // ----------------------------------------
   // design and controller
   // ----------------------------------------
   srh_ctrl_model ctrl (.clk(clk), .stat_req(stat_req), .common_req(common_req));
   srh_status #(.FREQ_W(15)) dut (.clk(clk), .sys_rst(sys_rst), .settling(settling),
      .sweep_in_progress(sweep_in_progress), .awaiting_trigger(awaiting_trigger), .freq_cond_in(freq_cond_in),
      .queue_not_empty(queue_not_empty), .output_message_available(output_message_available),
      .esr_set(esr_set), .stat_req(stat_req), .common_req(common_req), .stat_rdata(stat_rdata),
      .esr_rdata(esr_rdata), .status_byte(status_byte), .sre_q(sre_q), .ese_q(ese_q),
      .service_request(service_request));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // read a status register, data settles one cycle after the pulse
   task automatic rd_stat(input srh_pkg::srh_grp_e g, input srh_pkg::srh_reg_e s, output logic [15:0] v);
      ctrl.stat_op(1'b0, 1'b1, g, s, 16'h0000);
      @(posedge clk);
      #1 v = stat_rdata;
   endtask : rd_stat
   task automatic rd_esr(output logic [7:0] v);
      ctrl.com_op(4'h1, 8'h00);
      @(posedge clk);
      #1 v = esr_rdata;
   endtask : rd_esr
   // let synchronisers, event latches and status byte settle
   task automatic settle();
      repeat (6) @(posedge clk);
      #1;
   endtask : settle
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish
   // ceiling well above the hundred-odd cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_power_on();
      logic [7:0] v;
      rd_esr(v);
      chk({8'h00, v}, 16'h0080);
      chk({8'h00, status_byte}, 16'h0000);
      $display("power on test done");
   endtask : t_power_on
   task automatic t_std_event();
      logic [7:0] v;
      ctrl.com_op(4'h4, 8'h3C);
      @(posedge clk) esr_set <= 8'h3C;
      @(posedge clk) esr_set <= 8'h00;
      settle();
      chk({8'h00, status_byte}, 16'h0020);
      chk({8'h00, ese_q}, 16'h003C);
      rd_esr(v);
      chk({8'h00, v}, 16'h003C);
      rd_esr(v);
      chk({8'h00, v}, 16'h0000);
      $display("standard event test done");
   endtask : t_std_event
   task automatic t_operation();
      logic [15:0] v;
      ctrl.stat_op(1'b1, 1'b0, srh_pkg::SRH_GRP_OPER, srh_pkg::SRH_REG_ENA, 16'h002A);
      @(posedge clk) begin
         settling <= 1'b1;
         sweep_in_progress <= 1'b1;
         awaiting_trigger <= 1'b1;
      end
      settle();
      chk({8'h00, status_byte}, 16'h0080);
      ctrl.com_op(4'h2, 8'hC0);
      settle();
      chk({8'h00, sre_q}, 16'h0080);
      chk({8'h00, status_byte}, 16'h00C0);
      chk({15'h0000, service_request}, 16'h0001);
      ctrl.com_op(4'h2, 8'h00);
      settle();
      chk({15'h0000, service_request}, 16'h0000);
      rd_stat(srh_pkg::SRH_GRP_OPER, srh_pkg::SRH_REG_EVT, v);
      chk(v, 16'h002A);
      $display("operation test done");
   endtask : t_operation
   task automatic t_neg_filter();
      logic [15:0] v;
      ctrl.stat_op(1'b1, 1'b0, srh_pkg::SRH_GRP_OPER, srh_pkg::SRH_REG_PTR, 16'h0000);
      ctrl.stat_op(1'b1, 1'b0, srh_pkg::SRH_GRP_OPER, srh_pkg::SRH_REG_NTR, 16'h0002);
      @(posedge clk) begin
         settling <= 1'b0;
         sweep_in_progress <= 1'b0;
      end
      settle();
      rd_stat(srh_pkg::SRH_GRP_OPER, srh_pkg::SRH_REG_EVT, v);
      chk(v, 16'h0002);
      rd_stat(srh_pkg::SRH_GRP_OPER, srh_pkg::SRH_REG_EVT, v);
      chk(v, 16'h0000);
      $display("negative filter test done");
   endtask : t_neg_filter
   task automatic t_frequency();
      logic [15:0] v;
      ctrl.stat_op(1'b1, 1'b0, srh_pkg::SRH_GRP_FREQ, srh_pkg::SRH_REG_ENA, 16'h0001);
      ctrl.stat_op(1'b1, 1'b0, srh_pkg::SRH_GRP_QUES, srh_pkg::SRH_REG_ENA, 16'h0001);
      ctrl.stat_op(1'b1, 1'b0, srh_pkg::SRH_GRP_FREQ, srh_pkg::SRH_REG_PTR, 16'hFFFF);
      rd_stat(srh_pkg::SRH_GRP_FREQ, srh_pkg::SRH_REG_PTR, v);
      chk(v, 16'h7FFF);
      @(posedge clk) freq_cond_in <= 16'hFFFF;
      settle();
      settle();
      chk({8'h00, status_byte}, 16'h0008);
      rd_stat(srh_pkg::SRH_GRP_FREQ, srh_pkg::SRH_REG_EVT, v);
      chk(v, 16'h7FFF);
      rd_stat(srh_pkg::SRH_GRP_QUES, srh_pkg::SRH_REG_EVT, v);
      chk(v, 16'h0001);
      $display("frequency test done");
   endtask : t_frequency
   task automatic t_queue_and_clear();
      logic [7:0] v;
      @(posedge clk) begin
         queue_not_empty <= 1'b1;
         output_message_available <= 1'b1;
         esr_set <= 8'h20;
      end
      @(posedge clk) esr_set <= 8'h00;
      ctrl.com_op(4'h8, 8'h00);
      settle();
      chk({8'h00, status_byte}, 16'h0014);
      rd_esr(v);
      chk({8'h00, v}, 16'h0000);
      $display("queue and clear test done");
   endtask : t_queue_and_clear
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      t_power_on();
      t_std_event();
      t_operation();
      t_neg_filter();
      t_frequency();
      t_queue_and_clear();
      tally_and_finish();
   end
endmodule : testbench
